// File: rtl/ssipmf_defs.svh
`ifndef SSIPMF_DEFS_SVH
`define SSIPMF_DEFS_SVH

// Register byte offsets on the AHB-Lite slave.
`define SSIPMF_CFG_OFS      8'h00
`define SSIPMF_POS_OFS      8'h04
`define SSIPMF_STAT_OFS     8'h08
`define SSIPMF_MSG_OFS      8'h0C

// Configuration register fields.
`define SSIPMF_CFG_ERR_BIT  2
`define SSIPMF_CFG_ZDEF_BIT 3
`define SSIPMF_CFG_ERR_RST  1'h0
`define SSIPMF_CFG_ZDEF_RST 1'h1

// Status register fields.
`define SSIPMF_STAT_TS_LSB  0
`define SSIPMF_STAT_ST_LSB  12
`define SSIPMF_STAT_NB_LSB  16
`define SSIPMF_STAT_RES_LSB 24

// Checksum parameters.
`define SSIPMF_CRC_POLY     8'h97
`define SSIPMF_CRC_INIT     8'h00

// Timing, in nanoseconds.
`define SSIPMF_HCLK_NS      8
`define SSIPMF_TS_STEP_NS   1000
`define SSIPMF_TMU_NS       20000

`endif

// File: rtl/ssipmf_pkg.sv
package ssipmf_pkg;

	typedef enum logic [1:0] {
		FMT_CRC32     = 2'b00,
		FMT_PARITY30  = 2'b01,
		FMT_GRAY18    = 2'b10,
		FMT_TS32      = 2'b11
	} ssipmf_fmt_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_HOLD  = 2'b10
	} ssipmf_state_t;

endpackage

// File: rtl/ssipmf_sync2.sv
`timescale 1ns/100ps
module ssipmf_sync2 (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// Both stages reset high, the idle level of the link clock.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 1'h1;
			q      <= 1'h1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// File: rtl/ssipmf_formatter.sv
`timescale 1ns/100ps
`include "ssipmf_defs.svh"
// Overview of operation
// - Checksum is CRC-8, generator 0x97, start zero, MSB first, no inversion.
// - CRC format puts checksum in bits 31..24 over low 24 bits.
// - CRC format bit 23 is validity, complement of error indication.
// - Zero-origin factory flag at bit 22 (CRC) or bit 30 (stamped).
// - CRC format position in bits 21..0, unused upper bits zero.
// - Parity format bits 29..24 zero, position in bits 23..2.
// - Parity format bit 1 is odd parity indicator of bits 23..2.
// - Parity format bit 0 is the alarm, one on error.
// - Eighteen-bit format sends Gray-coded position in bits 17..0 only.
// - Eighteen-bit format caps resolution at 18 bits.
// - Stamped format bit 31 is validity, complement of error indication.
// - Stamped format position in bits 29..11, upper bits zero.
// - Stamped format bits 10..0 hold time stamp latched at measurement.
// - Eleven-bit stamp counter steps every 1 us and wraps to zero.
// - Stamped format caps resolution at 19 bits.
// - Lines idle high; each rising clock edge presents next bit, MSB first.
// - After last falling edge, 20 us update delay, then data high.
// - After final rising edge, data shows error indication until update ends.
// - Controller clock runs 100 kHz to 2 MHz; read lasts n periods plus half.
module ssipmf_formatter
	import ssipmf_pkg::*;
#(
	parameter ssipmf_fmt_t FORMAT   = FMT_CRC32,
	parameter int unsigned RES_BITS = 22
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ssi_clk,
	output logic             ssi_data
);
	localparam int unsigned TMU_CYC = `SSIPMF_TMU_NS / `SSIPMF_HCLK_NS;
	localparam int unsigned TS_CYC  = `SSIPMF_TS_STEP_NS / `SSIPMF_HCLK_NS;
	localparam int unsigned CAP     = (FORMAT == FMT_GRAY18) ? 18 :
	                                  (FORMAT == FMT_TS32) ? 19 : 22;
	localparam int unsigned EFF_RES = (RES_BITS < CAP) ? RES_BITS : CAP;
	localparam int unsigned N_BITS  = (FORMAT == FMT_PARITY30) ? 30 :
	                                  (FORMAT == FMT_GRAY18) ? 18 : 32;

	localparam logic [11:0] TMU_LAST = 12'(TMU_CYC - 1);
	localparam logic [7:0]  TS_LAST  = 8'(TS_CYC - 1);
	localparam logic [5:0]  MSG_BITS = 6'(N_BITS);
	localparam logic [4:0]  RES_FLD  = 5'(EFF_RES);
	localparam logic [21:0] POS_MASK = 22'((64'h1 << EFF_RES) - 64'h1);

	if (RES_BITS < 1 || RES_BITS > 22) begin : g_res_check
		$error("RES_BITS must lie between 1 and 22");
	end
	if (TMU_CYC > 4095 || TS_CYC > 255) begin : g_time_check
		$error("Clock rate too high for the timing counters");
	end

	ssipmf_state_t state_q;
	logic        cfg_err_q;
	logic        cfg_zdef_q;
	logic [21:0] pos_q;
	logic [10:0] ts_capt_q;
	logic [10:0] ts_cnt_q;
	logic [7:0]  ts_div_q;
	logic [31:0] msg_q;
	logic [5:0]  bit_idx_q;
	logic [11:0] tmu_q;
	logic        sclk_s;
	logic        sclk_prev_q;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [5:0]  idx_m1;
	logic        ahb_wr_q;
	logic        ahb_rd_q;
	logic [7:0]  ahb_addr_q;

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		logic       fb;
		c = `SSIPMF_CRC_INIT;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'h0};
			if (fb) begin
				c = c ^ `SSIPMF_CRC_POLY;
			end
		end
		return c;
	endfunction

	function automatic logic [31:0] build(input logic [21:0] pos,
	                                      input logic        err,
	                                      input logic        zdef,
	                                      input logic [10:0] ts);
		logic [31:0] m;
		m = 32'h0000_0000;
		case (FORMAT)
		FMT_CRC32: begin
			m[23] = ~err;
			m[22] = zdef;
			m[21:0] = pos;
			m[31:24] = crc8(m[23:0]);
		end
		FMT_PARITY30: begin
			m[23:2] = pos;
			m[1] = ^pos;
			m[0] = err;
		end
		FMT_GRAY18: begin
			m[17:0] = pos[17:0] ^ {1'h0, pos[17:1]};
		end
		FMT_TS32: begin
			m[31] = ~err;
			m[30] = zdef;
			m[29:11] = pos[18:0];
			m[10:0] = ts;
		end
		default: begin
			m = 32'h0000_0000;
		end
		endcase
		return m;
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
		`SSIPMF_CFG_OFS: begin
			r[1:0] = FORMAT;
			r[`SSIPMF_CFG_ERR_BIT] = cfg_err_q;
			r[`SSIPMF_CFG_ZDEF_BIT] = cfg_zdef_q;
		end
		`SSIPMF_POS_OFS: begin
			r[21:0] = pos_q;
		end
		`SSIPMF_STAT_OFS: begin
			r[`SSIPMF_STAT_TS_LSB +: 11] = ts_cnt_q;
			r[`SSIPMF_STAT_ST_LSB +: 2] = state_q;
			r[`SSIPMF_STAT_NB_LSB +: 6] = MSG_BITS;
			r[`SSIPMF_STAT_RES_LSB +: 5] = RES_FLD;
		end
		`SSIPMF_MSG_OFS: begin
			r = msg_q;
		end
		default: begin
			r = 32'h0000_0000;
		end
		endcase
		return r;
	endfunction

	// The link clock comes from the controller, so it is resynchronised
	// before any edge detection looks at it.
	ssipmf_sync2 u_sclk_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (ssi_clk),
		.q       (sclk_s)
	);

	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign sclk_fall = ~sclk_s & sclk_prev_q;
	assign idx_m1    = bit_idx_q - 6'h01;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_prev_q <= 1'h1;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	// AHB-Lite address phase capture and answer. Reads take one wait state
	// so that a write in the preceding data phase is always seen.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ahb_wr_q   <= 1'h0;
			ahb_rd_q   <= 1'h0;
			ahb_addr_q <= 8'h00;
			hreadyout  <= 1'h1;
			hrdata     <= 32'h0000_0000;
		end else begin
			ahb_wr_q <= 1'h0;
			ahb_rd_q <= 1'h0;
			if (ahb_rd_q) begin
				hrdata    <= reg_read(ahb_addr_q);
				hreadyout <= 1'h1;
			end else if (hready && hsel && htrans[1]) begin
				ahb_addr_q <= (haddr[31:8] == 24'h00_0000) ?
				              haddr[7:0] : 8'hFF;
				ahb_wr_q   <= hwrite;
				ahb_rd_q   <= ~hwrite;
				hreadyout  <= hwrite;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'h0;
		end else begin
			hresp <= 1'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_err_q  <= `SSIPMF_CFG_ERR_RST;
			cfg_zdef_q <= `SSIPMF_CFG_ZDEF_RST;
		end else if (ahb_wr_q && ahb_addr_q == `SSIPMF_CFG_OFS) begin
			cfg_err_q  <= hwdata[`SSIPMF_CFG_ERR_BIT];
			cfg_zdef_q <= hwdata[`SSIPMF_CFG_ZDEF_BIT];
		end
	end

	// A position write marks the measurement instant, so the stamp is
	// captured with it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_q     <= 22'h00_0000;
			ts_capt_q <= 11'h000;
		end else if (ahb_wr_q && ahb_addr_q == `SSIPMF_POS_OFS) begin
			pos_q     <= hwdata[21:0] & POS_MASK;
			ts_capt_q <= ts_cnt_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ts_div_q <= 8'h00;
			ts_cnt_q <= 11'h000;
		end else if (ts_div_q == TS_LAST) begin
			ts_div_q <= 8'h00;
			ts_cnt_q <= ts_cnt_q + 11'h001;
		end else begin
			ts_div_q <= ts_div_q + 8'h01;
		end
	end

	// Update delay timer, restarted by every falling link clock edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmu_q <= 12'h000;
		end else if (sclk_fall || state_q == ST_IDLE) begin
			tmu_q <= 12'h000;
		end else if (tmu_q != TMU_LAST) begin
			tmu_q <= tmu_q + 12'h001;
		end
	end

	// Link sequencer. A read that stalls mid-message also ends after the
	// update delay, so a lost controller cannot hang the line low.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q   <= ST_IDLE;
			ssi_data  <= 1'h1;
			msg_q     <= 32'h0000_0000;
			bit_idx_q <= 6'h00;
		end else begin
			case (state_q)
			ST_IDLE: begin
				ssi_data <= 1'h1;
				if (sclk_fall) begin
					msg_q     <= build(pos_q, cfg_err_q, cfg_zdef_q,
					                   ts_capt_q);
					bit_idx_q <= MSG_BITS;
					state_q   <= ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (sclk_rise && bit_idx_q != 6'h00) begin
					ssi_data  <= msg_q[idx_m1[4:0]];
					bit_idx_q <= idx_m1;
				end else if (sclk_rise) begin
					ssi_data <= cfg_err_q;
					state_q  <= ST_HOLD;
				end else if (tmu_q == TMU_LAST) begin
					ssi_data <= 1'h1;
					state_q  <= ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (tmu_q == TMU_LAST && !sclk_fall) begin
					ssi_data <= 1'h1;
					state_q  <= ST_IDLE;
				end
			end
			default: begin
				ssi_data <= 1'h1;
				state_q  <= ST_IDLE;
			end
			endcase
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_idle_line_high: assert property (
		state_q == ST_IDLE |-> ssi_data)
		else $error("Data line not high while idle.");

	a_crc_field_ok: assert property (
		FORMAT == FMT_CRC32 && state_q == ST_IDLE && sclk_fall
		|=> msg_q[31:24] == crc8(msg_q[23:0]))
		else $error("Checksum field does not match low 24 bits.");

	a_valid_flag: assert property (
		FORMAT == FMT_CRC32 && state_q == ST_IDLE && sclk_fall
		|=> msg_q[23] == !$past(cfg_err_q) && msg_q[22] == $past(cfg_zdef_q))
		else $error("Validity or zero flag wrong in checksum message.");

	a_stamp_flags: assert property (
		FORMAT == FMT_TS32 && state_q == ST_IDLE && sclk_fall
		|=> msg_q[31] == !$past(cfg_err_q) && msg_q[30] == $past(cfg_zdef_q)
		&& msg_q[10:0] == $past(ts_capt_q))
		else $error("Stamped message flags or stamp wrong.");

	a_parity_bits: assert property (
		FORMAT == FMT_PARITY30 && state_q == ST_IDLE && sclk_fall
		|=> msg_q[1] == ^msg_q[23:2] && msg_q[31:24] == 8'h00
		&& msg_q[0] == $past(cfg_err_q))
		else $error("Parity, alarm or zero bits wrong.");

	a_gray_width: assert property (
		FORMAT == FMT_GRAY18 && state_q == ST_IDLE && sclk_fall
		|=> msg_q[31:18] == 14'h0000)
		else $error("Gray message wider than 18 bits.");

	a_stamp_step: assert property (
		ts_div_q == TS_LAST
		|=> ts_cnt_q == $past(ts_cnt_q) + 11'h001 ##125 $changed(ts_cnt_q))
		else $error("Stamp counter does not step every 1 us.");

	a_msb_first: assert property (
		state_q == ST_SHIFT && sclk_rise && bit_idx_q == MSG_BITS
		|=> ssi_data == msg_q[N_BITS - 1])
		else $error("First bit sent is not the message MSB.");

	a_error_trail: assert property (
		state_q == ST_SHIFT && sclk_rise && bit_idx_q == 6'h00
		|=> state_q == ST_HOLD && ssi_data == $past(cfg_err_q))
		else $error("Trailing error indication missing.");

	a_update_end: assert property (
		state_q == ST_HOLD && tmu_q == TMU_LAST && !sclk_fall
		|=> state_q == ST_IDLE && ssi_data)
		else $error("Line not released after update delay.");

	a_msg_stable: assert property (
		state_q == ST_SHIFT && $past(state_q) == ST_SHIFT |-> $stable(msg_q))
		else $error("Message changed while shifting.");

endmodule

// File: sim/ssipmf_ctrl_model.sv
`timescale 1ns/100ps
module ssipmf_ctrl_model (
	output logic      ssi_clk,
	input  wire logic ssi_data
);
	initial ssi_clk = 1'b1;

	// Reads are taken on falling edges, half a period after each rise.
	task automatic read_word(input int n, input realtime half,
		output logic [31:0] w, output logic tail);
		w = '0;
		ssi_clk = 1'b0;
		#(half);
		for (int i = 0; i < n; i++) begin
			ssi_clk = 1'b1;
			#(half);
			ssi_clk = 1'b0;
			w = {w[30:0], ssi_data};
			#(half);
		end
		ssi_clk = 1'b1;
		#(half);
		tail = ssi_data;
	endtask
endmodule

// File: sim/ssi_position_message_formatter_tb.sv
`timescale 1ns/100ps
module ssi_position_message_formatter_tb;
	import ssipmf_pkg::*;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b0;
	logic             hwrite = 1'b0;
	logic [31:0]      haddr = '0;
	logic [31:0]      hwdata = '0;
	logic [1:0]       htrans = '0;
	logic [2:0]       hsize = 3'h2;
	logic [1:0]       sel = '0;
	logic [3:0][31:0] rdat;
	logic [3:0]       rdy, rsp, sdat;
	logic             hready, ssi_clk, tail;
	logic [31:0]      rd, w, t0, t1;
	int               fail_count = 0;
	int               tests_run = 0;
	int               cap [4] = '{22, 22, 18, 19};
	int               nbits [4] = '{32, 30, 18, 32};

	always #4 hclk = ~hclk;
	assign hready = rdy[sel];

	ssipmf_ctrl_model ctrl (.ssi_clk(ssi_clk), .ssi_data(sdat[sel]));

	for (genvar i = 0; i < 4; i++) begin : g
		ssipmf_formatter #(.FORMAT(ssipmf_fmt_t'(i))) uut (
			.hclk(hclk), .hresetn(hresetn), .hsel(hsel && sel == 2'(i)),
			.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
			.hwdata(hwdata), .hready(hready), .hrdata(rdat[i]),
			.hreadyout(rdy[i]), .hresp(rsp[i]), .ssi_clk(ssi_clk),
			.ssi_data(sdat[i]));
	end

	task automatic chk(input string nm, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = rdat[sel];
		chk("response", 32'(rsp[sel]), 32'h0);
	endtask

	function automatic logic [31:0] expect_word(input int f,
		input logic [21:0] p, input logic e, input logic z);
		logic [23:0] d;
		logic [7:0]  c;
		d = {~e, z, p};
		c = 8'h00;
		for (int b = 23; b >= 0; b--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? 8'h97 : 8'h00);
		case (f)
			0: return {c, d};
			1: return {8'h00, p, ^p, e};
			2: return {14'h0, p[17:0] ^ (p[17:0] >> 1)};
			default: return {~e, z, p[18:0], 11'h0};
		endcase
	endfunction

	task automatic run(input int f, input logic [21:0] p, input logic e,
		input logic z, input realtime half);
		logic [21:0] m;
		m = p & 22'((32'h1 << cap[f]) - 1);
		sel <= 2'(f);
		ahb(1'b1, 8'h00, {28'h0, z, e, 2'h0});
		ahb(1'b0, 8'h00, '0);
		chk("cfg", rd, {28'h0, z, e, 2'(f)});
		ahb(1'b0, 8'h08, '0);
		t0 = rd;
		ahb(1'b1, 8'h04, {10'h0, p});
		ahb(1'b0, 8'h08, '0);
		t1 = rd;
		chk("stat", rd & 32'h1F3F3000,
			{3'h0, 5'(cap[f]), 2'h0, 6'(nbits[f]), 16'h0});
		ahb(1'b0, 8'h04, '0);
		chk("pos", rd, {10'h0, m});
		fork
			ctrl.read_word(nbits[f], half, w, tail);
			begin
				#(half * 12);
				ahb(1'b1, 8'h04, 32'h0011_1111);
			end
		join
		chk("ssi word", w & (f == 3 ? 32'hFFFF_F800 : 32'hFFFF_FFFF),
			expect_word(f, m, e, z));
		if (f == 3)
			chk("stamp", 32'(w[10:0] == t0[10:0] || w[10:0] == t1[10:0]),
				32'h1);
		chk("tail", 32'(tail), 32'(e));
		#(19000.0 - half);
		chk("hold", 32'(sdat[sel]), 32'(e));
		#2000;
		chk("idle", 32'(sdat[sel]), 32'h1);
		ahb(1'b0, 8'h0C, '0);
		chk("msg reg", rd & (f == 3 ? 32'hFFFF_F800 : 32'hFFFF_FFFF),
			expect_word(f, m, e, z));
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 8'h00, '0);
		chk("cfg reset", rd, 32'h8);
		ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
		ahb(1'b0, 8'h10, '0);
		chk("unmapped", rd, 32'h0);
		ahb(1'b0, 8'h08, '0);
		t0 = rd;
		repeat (996) @(posedge hclk);
		ahb(1'b0, 8'h08, '0);
		chk("stamp step", (rd - t0) & 32'h7FF, 32'h8);
		for (int f = 0; f < 4; f++) begin
			run(f, 22'h3FFFFF, 1'b0, 1'b1, 62.5);
			run(f, 22'h02A5A5, 1'b1, 1'b0, 250.0);
		end
		conclude();
	end

	// The eight reads and register traffic need about 31000 cycles.
	initial begin
		repeat (80000) @(posedge hclk);
		fail_count++;
		conclude();
	end
endmodule
